//--- hdl/seia_access_regs.sv
// register bank for eeprom byte access and i/o expander signal access
// assumes the smbus engine runs on core_clk and answers each request with a
// one-cycle done pulse; its request lines are held high until that pulse
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
module seia_access_regs
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq,
  // eeprom engine request and completion
  output logic eeReq,
  output logic eeRead,
  output logic [15:0] eeAddr,
  output logic [7:0] eeWrData,
  input wire logic eeDone,
  input wire logic [7:0] eeRdData,
  // expander engine request and completion
  output logic expReq,
  output logic expReload,
  output logic [1:0] expIdx,
  output logic [15:0] expOutVal,
  input wire logic expDone,
  input wire logic [15:0] expInVal,
  input wire logic expInitDone,
  input wire logic [1:0] expInitIdx,
  // core side of the expanders, 1 marks an input pin
  input wire logic [2:0][15:0] expDirIn,
  input wire logic [2:0][15:0] coreExpOut
);

  typedef struct packed {
    logic awHave;
    logic [11:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [15:0] eeAddr;
    logic [7:0] eeData;
    logic eeOp;
    logic eeDone;
    seia_pkg::seia_eng_type eeState;
    logic [2:0] exSel;
    logic exTest;
    logic exDone;
    logic [2:0][15:0] swOut;
    logic [2:0][15:0] inVal;
    logic [2:0][15:0] outVal;
    seia_pkg::seia_eng_type exState;
    logic exReload;
    logic [1:0] exIdx;
    logic [15:0] exOut;
    logic [1:0] irqStat;
    logic [1:0] irqMask;
  } seia_state_type;

  seia_state_type st_r;
  seia_state_type st_nxt;

  // selector code to storage index; reserved codes give no valid index
  function automatic logic [2:0] selDecode(input logic [2:0] code);
    logic [2:0] res;
    res = 3'h0;
    unique case (code)
      seia_pkg::SEL_EXP0: res = 3'h4;
      seia_pkg::SEL_EXP2: res = 3'h5;
      seia_pkg::SEL_EXP4: res = 3'h6;
      default: res = 3'h0;
    endcase
    return res;
  endfunction

  // value of the outputs actually sent to an expander
  function automatic logic [15:0] supplied(input logic test, input logic [15:0] sw,
                                           input logic [15:0] core);
    return test ? sw : core;
  endfunction

  logic wrFire;
  logic rdFire;
  logic [2:0] curSel;
  logic [15:0] selRead;
  logic [31:0] eeWord;
  logic [31:0] exWord;

  assign wrFire = st_r.awHave && st_r.wHave && !st_r.bValid;
  assign rdFire = s_axi_arvalid && !st_r.rValid;
  assign curSel = selDecode(st_r.exSel);

  // read view of the selected expander: inputs as fetched, outputs as supplied
  // (RL8) per-pin data view
  always_comb
  begin
    selRead = 16'h0000;
    if (curSel[2])
    begin
      selRead = (st_r.inVal[curSel[1:0]] & expDirIn[curSel[1:0]])
              | (st_r.outVal[curSel[1:0]] & ~expDirIn[curSel[1:0]]);
    end
  end

  // register read words; reserved bits and the refresh trigger read zero
  always_comb
  begin
    eeWord = 32'h0000_0000;
    // (RL1) stored byte address
    eeWord[seia_pkg::EE_ADDR_LSB +: 16] = st_r.eeAddr;
    eeWord[seia_pkg::EE_DATA_LSB +: 8] = st_r.eeData;
    // (RL5) busy while engine waits
    eeWord[seia_pkg::EE_BUSY_BIT] = (st_r.eeState == seia_pkg::ENG_WAIT);
    eeWord[seia_pkg::EE_DONE_BIT] = st_r.eeDone;
    eeWord[seia_pkg::EE_OP_BIT] = st_r.eeOp;
    exWord = 32'h0000_0000;
    exWord[seia_pkg::EX_DATA_LSB +: 16] = selRead;
    exWord[seia_pkg::EX_TEST_BIT] = st_r.exTest;
    exWord[seia_pkg::EX_SEL_LSB +: 3] = st_r.exSel;
    exWord[seia_pkg::EX_DONE_BIT] = st_r.exDone;
  end

  // next-state logic: bus slave, eeprom launcher, expander launcher, interrupts
  always_comb
  begin
    logic [31:0] wd;
    logic [3:0] ws;
    logic eeHit;
    logic exHit;
    logic stHit;
    logic mkHit;
    logic eeClr;
    logic exClr;
    logic exSet;
    logic [2:0] wrSel;
    logic exLaunch;
    logic exLaunchReload;
    logic [15:0] wrMask;
    st_nxt = st_r;
    wd = st_r.wData;
    ws = st_r.wStrb;
    eeHit = wrFire && (st_r.awAddr == seia_pkg::EEPROM_CTL_OFS);
    exHit = wrFire && (st_r.awAddr == seia_pkg::EXPANDER_CTL_OFS);
    stHit = wrFire && (st_r.awAddr == seia_pkg::IRQ_STATUS_OFS);
    mkHit = wrFire && (st_r.awAddr == seia_pkg::IRQ_MASK_OFS);
    eeClr = eeHit && ws[3] && wd[seia_pkg::EE_DONE_BIT];
    exClr = exHit && ws[3] && wd[seia_pkg::EX_DONE_BIT];
    exSet = 1'b0;
    exLaunch = 1'b0;
    exLaunchReload = 1'b0;
    wrSel = curSel;
    wrMask = 16'h0000;

    // capture address and data in either order
    if (s_axi_awvalid && !st_r.awHave)
    begin
      st_nxt.awHave = 1'b1;
      st_nxt.awAddr = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && !st_r.wHave)
    begin
      st_nxt.wHave = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (wrFire)
    begin
      st_nxt.awHave = 1'b0;
      st_nxt.wHave = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp = (eeHit || exHit || stHit || mkHit) ? seia_pkg::AXI_OKAY
                                                         : seia_pkg::AXI_DECERR;
    end
    if (st_r.bValid && s_axi_bready)
    begin
      st_nxt.bValid = 1'b0;
    end

    // eeprom register write: address and op stored, data lane launches
    if (eeHit)
    begin
      // (RL1) address bytes
      // frozen while busy so the engine keeps one target per operation
      if (ws[0] && st_r.eeState == seia_pkg::ENG_IDLE)
      begin
        st_nxt.eeAddr[7:0] = wd[7:0];
      end
      if (ws[1] && st_r.eeState == seia_pkg::ENG_IDLE)
      begin
        st_nxt.eeAddr[15:8] = wd[15:8];
      end
      // (RL7) op select bit
      if (ws[3] && st_r.eeState == seia_pkg::ENG_IDLE)
      begin
        st_nxt.eeOp = wd[seia_pkg::EE_OP_BIT];
      end
      // (RL2) data write launches
      // (RL14) a launch while busy is dropped
      if (ws[2] && st_r.eeState == seia_pkg::ENG_IDLE)
      begin
        st_nxt.eeState = seia_pkg::ENG_WAIT;
        // (RL3) keep byte to write
        // (RL4) read keeps old byte
        if ((ws[3] ? wd[seia_pkg::EE_OP_BIT] : st_r.eeOp) == seia_pkg::EE_OP_WRITE)
        begin
          st_nxt.eeData = wd[seia_pkg::EE_DATA_LSB +: 8];
        end
      end
    end

    // eeprom completion; the set wins over a same-cycle clear
    // (RL6) done set, write-one clear
    if (eeClr)
    begin
      st_nxt.eeDone = 1'b0;
    end
    if (st_r.eeState == seia_pkg::ENG_WAIT && eeDone)
    begin
      st_nxt.eeState = seia_pkg::ENG_IDLE;
      st_nxt.eeDone = 1'b1;
      // (RL4) fetched byte readable
      if (st_r.eeOp == seia_pkg::EE_OP_READ)
      begin
        st_nxt.eeData = eeRdData;
      end
    end

    // expander register write; new selector applies to the same write
    if (exHit)
    begin
      if (ws[3])
      begin
        st_nxt.exTest = wd[seia_pkg::EX_TEST_BIT];
        // (RL12) selector stored
        st_nxt.exSel = wd[seia_pkg::EX_SEL_LSB +: 3];
        wrSel = selDecode(wd[seia_pkg::EX_SEL_LSB +: 3]);
      end
      wrMask = {{8{ws[1]}}, {8{ws[0]}}};
      // (RL10) input bits refuse writes
      if (wrSel[2])
      begin
        wrMask = wrMask & ~expDirIn[wrSel[1:0]];
        st_nxt.swOut[wrSel[1:0]] = (st_r.swOut[wrSel[1:0]] & ~wrMask)
                                 | (wd[15:0] & wrMask);
      end
      // (RL11) trigger starts reload
      if (ws[3] && wd[seia_pkg::EX_RELOAD_BIT])
      begin
        exLaunch = wrSel[2];
        exLaunchReload = 1'b1;
      end
      else if ((ws[0] || ws[1]) && (ws[3] ? wd[seia_pkg::EX_TEST_BIT] : st_r.exTest))
      begin
        exLaunch = wrSel[2];
      end
    end

    // launch one expander transaction when the engine is free
    if (exLaunch && st_r.exState == seia_pkg::ENG_IDLE)
    begin
      st_nxt.exState = seia_pkg::ENG_WAIT;
      st_nxt.exReload = exLaunchReload;
      st_nxt.exIdx = wrSel[1:0];
      // (RL9) test mode overrides core
      st_nxt.exOut = supplied(ws[3] ? wd[seia_pkg::EX_TEST_BIT] : st_r.exTest,
                              st_nxt.swOut[wrSel[1:0]], coreExpOut[wrSel[1:0]]);
    end

    // expander completion: latch supplied outputs, and fetched inputs on a reload
    if (st_r.exState == seia_pkg::ENG_WAIT && expDone)
    begin
      st_nxt.exState = seia_pkg::ENG_IDLE;
      st_nxt.outVal[st_r.exIdx] = st_r.exOut;
      if (st_r.exReload)
      begin
        st_nxt.inVal[st_r.exIdx] = expInVal;
      end
      // (RL13) done for chosen expander
      if (curSel[2] && curSel[1:0] == st_r.exIdx)
      begin
        exSet = 1'b1;
      end
    end
    // (RL13) init sequence completion
    if (expInitDone && curSel[2] && curSel[1:0] == expInitIdx)
    begin
      exSet = 1'b1;
    end
    if (exClr)
    begin
      st_nxt.exDone = 1'b0;
    end
    if (exSet)
    begin
      st_nxt.exDone = 1'b1;
    end

    // sticky interrupt status, set beats write-one clear
    if (stHit && ws[0])
    begin
      st_nxt.irqStat = st_r.irqStat & ~wd[1:0];
    end
    if (mkHit && ws[0])
    begin
      st_nxt.irqMask = wd[1:0];
    end
    if (st_r.eeState == seia_pkg::ENG_WAIT && eeDone)
    begin
      st_nxt.irqStat[seia_pkg::IRQ_EE_BIT] = 1'b1;
    end
    if (exSet)
    begin
      st_nxt.irqStat[seia_pkg::IRQ_EX_BIT] = 1'b1;
    end

    // read channel: one-cycle answer, data sampled at acceptance
    if (rdFire)
    begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp = seia_pkg::AXI_OKAY;
      unique case ({s_axi_araddr[11:2], 2'b00})
        seia_pkg::EEPROM_CTL_OFS: st_nxt.rData = eeWord;
        seia_pkg::EXPANDER_CTL_OFS: st_nxt.rData = exWord;
        seia_pkg::IRQ_STATUS_OFS: st_nxt.rData = {30'h0000_0000, st_r.irqStat};
        seia_pkg::IRQ_MASK_OFS: st_nxt.rData = {30'h0000_0000, st_r.irqMask};
        default:
        begin
          st_nxt.rData = 32'h0000_0000;
          st_nxt.rResp = seia_pkg::AXI_DECERR;
        end
      endcase
    end
    else if (st_r.rValid && s_axi_rready)
    begin
      st_nxt.rValid = 1'b0;
    end

    // synchronous reset to documented defaults
    if (!nrst)
    begin
      st_nxt = '0;
      st_nxt.eeAddr = seia_pkg::RST_ADDR;
      st_nxt.eeData = seia_pkg::RST_DATA;
      st_nxt.exSel = seia_pkg::RST_SEL;
      st_nxt.irqStat = seia_pkg::RST_IRQ;
      st_nxt.irqMask = seia_pkg::RST_IRQ;
      st_nxt.eeState = seia_pkg::ENG_IDLE;
      st_nxt.exState = seia_pkg::ENG_IDLE;
    end
  end

  // single state register
  always_ff @(posedge core_clk)
  begin
    st_r <= st_nxt;
  end

  // bus handshakes and data all come from the state register, with no path from inputs
  assign s_axi_awready = !st_r.awHave;
  assign s_axi_wready = !st_r.wHave;
  assign s_axi_bvalid = st_r.bValid;
  assign s_axi_bresp = st_r.bResp;
  assign s_axi_arready = !st_r.rValid;
  assign s_axi_rvalid = st_r.rValid;
  assign s_axi_rdata = st_r.rData;
  assign s_axi_rresp = st_r.rResp;
  assign irq = |(st_r.irqStat & st_r.irqMask);

  // engine requests held until the engine's done pulse
  assign eeReq = (st_r.eeState == seia_pkg::ENG_WAIT);
  assign eeRead = st_r.eeOp;
  assign eeAddr = st_r.eeAddr;
  assign eeWrData = st_r.eeData;
  assign expReq = (st_r.exState == seia_pkg::ENG_WAIT);
  assign expReload = st_r.exReload;
  assign expIdx = st_r.exIdx;
  assign expOutVal = st_r.exOut;

endmodule

//--- hdl/seia_pkg.sv
// package for the serial eeprom and i/o expander access registers
// assumes one core clock, an axi4-lite master and an outside smbus engine
// What this block does
// (RL1) hold 16-bit eeprom byte address
// (RL2) data-field write launches one eeprom operation
// (RL3) write operation sends written data byte
// (RL4) read ignores written byte, returns fetched byte
// (RL5) busy flag high during eeprom operation
// (RL6) done flag set on finish, write-one-clear
// (RL7) op select: zero writes, one reads
// (RL8) signal bits show last inputs and outputs
// (RL9) test mode sends software values to outputs
// (RL10) input signal bits ignore software writes
// (RL11) refresh trigger starts reload, reads zero
// (RL12) selector codes 0, 2, 4 pick expander
// (RL13) expander done flag set on completions of the selected expander
// (RL14) software waits for idle before relaunching
package seia_pkg;
  // register byte addresses
  localparam logic [11:0] EEPROM_CTL_OFS = 12'h42C;
  localparam logic [11:0] EXPANDER_CTL_OFS = 12'h430;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h440;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h444;
  // eeprom access field positions
  localparam int EE_ADDR_LSB = 0;
  localparam int EE_DATA_LSB = 16;
  localparam int EE_BUSY_BIT = 24;
  localparam int EE_DONE_BIT = 25;
  localparam int EE_OP_BIT = 26;
  // expander access field positions
  localparam int EX_DATA_LSB = 0;
  localparam int EX_RELOAD_BIT = 24;
  localparam int EX_TEST_BIT = 25;
  localparam int EX_SEL_LSB = 28;
  localparam int EX_DONE_BIT = 31;
  // interrupt status bits
  localparam int IRQ_EE_BIT = 0;
  localparam int IRQ_EX_BIT = 1;
  // operation and selector encodings
  localparam logic EE_OP_WRITE = 1'b0;
  localparam logic EE_OP_READ = 1'b1;
  localparam logic [2:0] SEL_EXP0 = 3'h0;
  localparam logic [2:0] SEL_EXP2 = 3'h2;
  localparam logic [2:0] SEL_EXP4 = 3'h4;
  // values after reset and bus response codes
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;
  // engine handshake state
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_WAIT = 2'b01
  } seia_eng_type;
endpackage

//--- sim/seia_access_regs_chk.sv
// checker for the eeprom and expander access registers
// sees top ports only; one core clock, sync active-low reset
`timescale 1ns/100ps
module seia_access_regs_chk
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // engine requests
  input wire logic eeReq,
  input wire logic eeRead,
  input wire logic [15:0] eeAddr,
  input wire logic [7:0] eeWrData,
  input wire logic eeDone,
  input wire logic expReq,
  input wire logic expReload,
  input wire logic [1:0] expIdx,
  input wire logic expDone
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // one answer per bus request
  bresp_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  rdata_end_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // engine requests stand frozen until their done pulse
  ee_hold_a: assert property (eeReq && !eeDone |=>
      eeReq && $stable({eeRead, eeAddr, eeWrData}))
    else $error("eeprom request dropped or changed");
  ee_end_a: assert property (eeReq && eeDone |=> !eeReq)
    else $error("eeprom request outlives done");
  exp_hold_a: assert property (expReq && !expDone |=>
      expReq && $stable({expIdx, expReload}))
    else $error("expander request dropped or changed");
  exp_end_a: assert property (expReq && expDone |=> !expReq)
    else $error("expander request outlives done");
  exp_sel_a: assert property (expReq |-> expIdx != 2'h3)
    else $error("request to reserved expander");
endmodule

//--- sim/seia_smbus_model.sv
// behavioural smbus engine standing in for the eeprom and expanders
// assumes requests held until the one-cycle done pulse
`timescale 1ns/100ps
module seia_smbus_model
#(
  parameter logic [15:0] IN_BASE = 16'h3C5A
)
(
  // clock, reset and pace
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic slow,
  // eeprom side
  input wire logic eeReq,
  input wire logic eeRead,
  input wire logic [15:0] eeAddr,
  input wire logic [7:0] eeWrData,
  output logic eeDone,
  output logic [7:0] eeRdData,
  // expander side
  input wire logic expReq,
  input wire logic [1:0] expIdx,
  output logic expDone,
  output logic [15:0] expInVal
);
  logic [7:0] mem [0:65535];
  logic [7:0] rdByte;
  logic [15:0] pinVal;
  logic eeHold, exHold;
  int eeCnt, exCnt;
  // known contents so a fetched byte is told apart from a stored one
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'hA5;
    rdByte = 8'h00;
    pinVal = 16'h0000;
  end
  // eeprom: hold off until the request drops, so one pulse per request
  always @(posedge core_clk)
  begin
    eeDone <= 1'b0;
    eeCnt <= eeCnt + 1;
    if (!nrst || !eeReq)
    begin
      eeCnt <= 0;
      eeHold <= 1'b0;
    end
    else if (eeHold)
      eeCnt <= 0;
    else if (eeCnt == (slow ? 20 : 2))
    begin
      eeDone <= 1'b1;
      eeHold <= 1'b1;
      rdByte <= mem[eeAddr];
      if (!eeRead)
        mem[eeAddr] <= eeWrData;
    end
  end
  // expander: fetched pins depend on the index asked for
  always @(posedge core_clk)
  begin
    expDone <= 1'b0;
    exCnt <= exCnt + 1;
    if (!nrst || !expReq)
    begin
      exCnt <= 0;
      exHold <= 1'b0;
    end
    else if (exHold)
      exCnt <= 0;
    else if (exCnt == 3)
    begin
      expDone <= 1'b1;
      exHold <= 1'b1;
      pinVal <= IN_BASE ^ {14'h0, expIdx};
    end
  end
  // outside done the data lines show no stale value
  assign eeRdData = eeDone ? rdByte : ~rdByte;
  assign expInVal = expDone ? pinVal : ~pinVal;
endmodule

//--- sim/seia_access_regs_tb_top.sv
// self-checking bench for the eeprom and expander access registers
// assumes the smbus engine model and the checker bound at the foot
`timescale 1ns/100ps
module seia_access_regs_tb_top;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] r;
    logic [31:0] q;
  } seia_row_type;
  localparam logic [11:0] EE = seia_pkg::EEPROM_CTL_OFS;
  localparam logic [11:0] EX = seia_pkg::EXPANDER_CTL_OFS;
  localparam logic [11:0] ST = seia_pkg::IRQ_STATUS_OFS;
  localparam logic [11:0] MK = seia_pkg::IRQ_MASK_OFS;
  localparam logic [15:0] IN_BASE = 16'h3C5A;
  logic core_clk, nrst, slow, irq, eeReq, eeRead, eeDone, expReq, expReload, expDone;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, expInitDone;
  logic [1:0] s_axi_bresp, s_axi_rresp, expIdx, expInitIdx, r;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [15:0] eeAddr, expOutVal, expInVal;
  logic [7:0] eeWrData, eeRdData;
  logic [2:0][15:0] expDirIn, coreExpOut;
  int error_cnt = 0;
  int checks = 0;
  seia_row_type rows [5] = '{'{MK, 32'h3, 4'hF, 2'h0, 32'h3},
    '{EE, 32'h1234, 4'h3, 2'h0, 32'h1234}, '{12'h448, 32'hFFFFFFFF, 4'hF, 2'h3, 32'h0},
    '{EX, 32'h50000000, 4'h8, 2'h0, 32'h50000000}, '{EX, 32'h20000000, 4'h8, 2'h0, 32'h20000000}};
  seia_access_regs u_seia_access_regs (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .eeReq, .eeRead, .eeAddr, .eeWrData,
    .eeDone, .eeRdData, .expReq, .expReload, .expIdx, .expOutVal, .expDone, .expInVal,
    .expInitDone, .expInitIdx, .expDirIn, .coreExpOut);
  seia_smbus_model #(.IN_BASE(IN_BASE)) u_seia_smbus_model (.core_clk, .nrst, .slow, .eeReq,
    .eeRead, .eeAddr, .eeWrData, .eeDone, .eeRdData, .expReq, .expIdx, .expDone, .expInVal);
  // 125 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // write: hold each channel until taken, bready until the answer
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge core_clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a);
    logic ta, tb;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge core_clk);
      ta = s_axi_arready;
      tb = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end while (!tb);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  // bounded poll until a flag reads one
  task automatic waitbit(input logic [11:0] a, input int b);
    int n;
    n = 0;
    do
    begin
      rd(a);
      n++;
    end while (v[b] !== 1'b1 && n < 200);
    cmp(32'(v[b]), 32'h1);
  endtask
  task automatic complete_run;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {nrst, slow, expInitDone, expInitIdx} = 5'h0;
    expDirIn = {3{16'h00FF}};
    coreExpOut = {16'h0F0F, 16'h5555, 16'hAAAA};
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    // every register starts cleared
    foreach (rows[i])
    begin
      rd(i < 2 ? EE + 12'(4 * i) : ST + 12'(4 * (i - 2)));
      cmp(v, 32'h0);
    end
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d, rows[i].s);
      cmp(32'(r), 32'(rows[i].r));
      rd(rows[i].a);
      cmp(v, rows[i].q);
    end
    // reload each expander: fetched inputs beside core outputs
    for (int i = 0; i < 3; i++)
    begin
      wr(EX, 32'h81000000 | (32'(2 * i) << 28), 4'h8);
      waitbit(EX, 31);
      cmp(v, 32'h80000000 | (32'(2 * i) << 28) | 32'((IN_BASE ^ 16'(i)) & 16'h00FF
        | coreExpOut[i] & 16'hFF00));
    end
    cmp(32'(irq), 32'h1);
    wr(ST, 32'h3, 4'hF);
    wr(MK, 32'h1, 4'hF);
    // test mode: written outputs reach the pins, input bits ignore writes
    wr(EX, 32'h82000000, 4'h8);
    wr(EX, 32'h02001234, 4'hB);
    waitbit(EX, 31);
    cmp(v, 32'h82000000 | 32'(IN_BASE & 16'h00FF | 16'h1200));
    cmp(32'(expOutVal), 32'h1200);
    cmp(32'(irq), 32'h0);
    wr(MK, 32'h3, 4'hF);
    cmp(32'(irq), 32'h1);
    wr(ST, 32'h2, 4'hF);
    cmp(32'(irq), 32'h0);
    // init completion counts only for the selected expander
    wr(EX, 32'h82000000, 4'h8);
    for (int j = 1; j >= 0; j--)
    begin
      expInitIdx <= 2'(j);
      expInitDone <= 1'b1;
      @(posedge core_clk);
      expInitDone <= 1'b0;
      rd(EX);
      cmp(32'(v[31]), 32'(j == 0));
    end
    // clear the expander status so the eeprom interrupt is seen alone
    wr(ST, 32'h2, 4'hF);
    // slow eeprom write, busy seen mid-way
    slow <= 1'b1;
    wr(EE, 32'h005A1234, 4'hF);
    rd(EE);
    cmp(32'(v[24]), 32'h1);
    waitbit(EE, 25);
    cmp(v, 32'h025A1234);
    cmp(32'(u_seia_smbus_model.mem[16'h1234]), 32'h5A);
    cmp(32'(irq), 32'h1);
    wr(EE, 32'h0, 4'h8);
    rd(EE);
    cmp(v, 32'h025A1234);
    wr(EE, 32'h02000000, 4'h8);
    rd(EE);
    cmp(v, 32'h005A1234);
    // read at a new address; the launching byte is dropped
    slow <= 1'b0;
    wr(EE, 32'h04000077, 4'hB);
    wr(EE, 32'h04FF0077, 4'hF);
    waitbit(EE, 25);
    cmp(v, 32'h06D20077);
    complete_run();
  end
endmodule
bind seia_access_regs seia_access_regs_chk u_seia_access_regs_chk (.core_clk, .nrst,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .eeReq, .eeRead, .eeAddr, .eeWrData, .eeDone, .expReq, .expReload, .expIdx, .expDone);
